// ---- hdl/aiatm_map.svh ----
/*
  Register offsets, field positions, reset values and timing constants
  of the analog input alarm and trip monitor.
  Assumes a 10 MHz system clock and a byte-addressed 32-bit register port.
*/
`ifndef AIATM_MAP_SVH
`define AIATM_MAP_SVH

// Register byte offsets
`define AIATM_OFF_ELEM_BASE   8'h00  // Level at +0, delay at +4, 8 per element
`define AIATM_OFF_GRACE_LO    8'h20
`define AIATM_OFF_GRACE_HI    8'h24
`define AIATM_OFF_MIN_SCALE   8'h28
`define AIATM_OFF_MAX_SCALE   8'h2C
`define AIATM_OFF_STATUS      8'h30
`define AIATM_OFF_SCALED      8'h34
`define AIATM_OFF_TRIP_CLR    8'h38

// Status field positions
`define AIATM_ST_ALARM_LO     0
`define AIATM_ST_ALARM_HI     1
`define AIATM_ST_TRIP_LO      2
`define AIATM_ST_TRIP_HI      3
`define AIATM_ST_GRACE_LO     4
`define AIATM_ST_GRACE_HI     5

// Reset values
`define AIATM_RST_LEVEL       15'h0000  // Level 0 means off
`define AIATM_RST_DELAY       10'h0005  // 5 s, delay 0 means off
`define AIATM_RST_GRACE       10'h0005  // 5 s
`define AIATM_GRACE_OFF       10'h03FF  // Start grace disabled
`define AIATM_RST_MIN_SCALE   15'h0000
`define AIATM_RST_MAX_SCALE   15'h03E8  // 1000

// Loop code: 0 at 4 mA, 4096 at 20 mA
`define AIATM_CODE_FULL       13'h1000
`define AIATM_CODE_SHIFT      12

// Timebase
`define AIATM_CLK_PERIOD_NS   100
`define AIATM_SECOND_NS       1000000000
`define AIATM_SECOND_CYCLES   (`AIATM_SECOND_NS / `AIATM_CLK_PERIOD_NS)

`endif

// ---- hdl/aiatm_monitor.sv ----
/*
  Analog input alarm and trip monitor: scales the 4 to 20 mA loop code,
  checks it against two alarm and two trip thresholds with qualifying
  delays, and applies a start grace window to each trip threshold.
  Assumes loop code, start and running inputs synchronous to clock_i.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
`include "aiatm_map.svh"
`default_nettype none

module aiatm_monitor #(
  parameter int TICK_CYCLES = `AIATM_SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic      [31:0] rdata_o,
  // Transducer loop and motor state
  input  wire logic [12:0] loop_code_i,
  input  wire logic        motor_start_i,
  input  wire logic        motor_running_i,
  // Events to motor control
  output logic             alarm_low_o,
  output logic             alarm_high_o,
  output logic             trip_low_o,
  output logic             trip_high_o
);
  aiatm_pkg::aiatm_level_t   level_q [4];
  aiatm_pkg::aiatm_seconds_t delay_q [4];
  aiatm_pkg::aiatm_seconds_t grace_q [2];
  aiatm_pkg::aiatm_level_t   min_scale_q;
  aiatm_pkg::aiatm_level_t   max_scale_q;
  aiatm_pkg::aiatm_level_t   scaled_q;
  aiatm_pkg::aiatm_seconds_t grace_cnt_q [2];
  logic [1:0]                grace_win_q;
  logic [1:0]                trip_q;
  logic [1:0]                trip_set;
  logic [3:0]                cond;
  logic [3:0]                elem_en;
  logic [3:0]                qualified;
  logic [23:0]               tick_cnt_q;
  logic                      tick_q;

  // True when the address selects element n's level or delay word
  function automatic logic elem_hit(input logic [7:0] a, input int n,
                                    input logic dly);
    return a == (`AIATM_OFF_ELEM_BASE + 8'(8 * n) + (dly ? 8'h04 : 8'h00));
  endfunction

  // One-second tick divider
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h00_0001;
      tick_q     <= 1'b0;
    end
  end

  // Setpoint writes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int n = 0; n < 4; n++) begin
        level_q[n] <= `AIATM_RST_LEVEL;
        delay_q[n] <= `AIATM_RST_DELAY;
      end
      grace_q[0]  <= `AIATM_RST_GRACE;
      grace_q[1]  <= `AIATM_RST_GRACE;
      min_scale_q <= `AIATM_RST_MIN_SCALE;
      max_scale_q <= `AIATM_RST_MAX_SCALE;
    end else if (write_i) begin
      for (int n = 0; n < 4; n++) begin
        if (elem_hit(addr_i, n, 1'b0)) begin
          level_q[n] <= wdata_i[14:0];
        end else if (elem_hit(addr_i, n, 1'b1)) begin
          delay_q[n] <= wdata_i[9:0];
        end
      end
      if (addr_i == `AIATM_OFF_GRACE_LO) begin
        grace_q[0] <= wdata_i[9:0];
      end else if (addr_i == `AIATM_OFF_GRACE_HI) begin
        grace_q[1] <= wdata_i[9:0];
      end else if (addr_i == `AIATM_OFF_MIN_SCALE) begin
        min_scale_q <= wdata_i[14:0];
      end else if (addr_i == `AIATM_OFF_MAX_SCALE) begin
        max_scale_q <= wdata_i[14:0];
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (read_i) begin
      rdata_o <= '0;
      for (int n = 0; n < 4; n++) begin
        if (elem_hit(addr_i, n, 1'b0)) begin
          rdata_o <= {17'h0_0000, level_q[n]};
        end else if (elem_hit(addr_i, n, 1'b1)) begin
          rdata_o <= {22'h00_0000, delay_q[n]};
        end
      end
      if (addr_i == `AIATM_OFF_GRACE_LO) begin
        rdata_o <= {22'h00_0000, grace_q[0]};
      end else if (addr_i == `AIATM_OFF_GRACE_HI) begin
        rdata_o <= {22'h00_0000, grace_q[1]};
      end else if (addr_i == `AIATM_OFF_MIN_SCALE) begin
        rdata_o <= {17'h0_0000, min_scale_q};
      end else if (addr_i == `AIATM_OFF_MAX_SCALE) begin
        rdata_o <= {17'h0_0000, max_scale_q};
      end else if (addr_i == `AIATM_OFF_STATUS) begin
        rdata_o <= {26'h000_0000, grace_win_q, trip_q,
                    alarm_high_o, alarm_low_o};
      end else if (addr_i == `AIATM_OFF_SCALED) begin
        rdata_o <= {17'h0_0000, scaled_q};
      end
    end
  end

  // Linear scaling of the loop code between the scale endpoints
  always_ff @(posedge clock_i) begin
    logic [12:0] code;
    logic [14:0] span;
    logic [27:0] prod;
    code = '0;
    span = '0;
    prod = '0;
    if (!resetn_i) begin
      scaled_q <= '0;
    end else begin
      code = (loop_code_i > `AIATM_CODE_FULL) ? `AIATM_CODE_FULL
                                               : loop_code_i;
      span = (max_scale_q > min_scale_q) ? max_scale_q - min_scale_q
                                         : 15'h0000;
      prod = 28'(code) * 28'(span);
      scaled_q <= min_scale_q + prod[`AIATM_CODE_SHIFT +: 15];
    end
  end

  // Threshold conditions; level zero keeps the element inactive
  assign cond[0] = (level_q[0] != '0) && (scaled_q < level_q[0]);
  assign cond[1] = (level_q[1] != '0) && (scaled_q > level_q[1]);
  assign cond[2] = (level_q[2] != '0) && (scaled_q < level_q[2]);
  assign cond[3] = (level_q[3] != '0) && (scaled_q > level_q[3]);

  // Alarms always armed; trips armed with grace off, or while running outside the window
  assign elem_en[0] = 1'b1;
  assign elem_en[1] = 1'b1;

  // Per-element qualifying delay timers
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_elem
      aiatm_qual_timer #(.W(10)) u_timer (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .tick_i      (tick_q),
        .enable_i    (elem_en[g]),
        .cond_i      (cond[g]),
        .delay_i     (delay_q[g]),
        .qualified_o (qualified[g])
      );
    end
  endgenerate

  // Start grace window for each trip threshold
  generate
    for (g = 0; g < 2; g++) begin : g_grace
      logic grace_off;
      logic unhealthy;
      assign grace_off  = grace_q[g] == `AIATM_GRACE_OFF;
      assign unhealthy  = cond[g + 2];
      assign elem_en[g + 2] = grace_off ||
                              (motor_running_i && !grace_win_q[g]);

      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          grace_win_q[g] <= 1'b0;
          grace_cnt_q[g] <= '0;
          trip_set[g]    <= 1'b0;
        end else begin
          trip_set[g] <= 1'b0;
          if (grace_off) begin
            grace_win_q[g] <= 1'b0;
          end else if (motor_start_i) begin
            grace_cnt_q[g] <= '0;
            if (grace_q[g] == '0) begin
              grace_win_q[g] <= 1'b0;
              trip_set[g]    <= unhealthy;
            end else begin
              grace_win_q[g] <= 1'b1;
            end
          end else if (grace_win_q[g]) begin
            if (!unhealthy) begin
              grace_win_q[g] <= 1'b0;
            end else if (tick_q) begin
              grace_cnt_q[g] <= grace_cnt_q[g] + 10'h001;
              if (grace_cnt_q[g] + 10'h001 >= grace_q[g]) begin
                grace_win_q[g] <= 1'b0;
                trip_set[g]    <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

  // Latched trips, cleared by writing ones; a new trip wins over a clear
  always_ff @(posedge clock_i) begin
    logic [1:0] clr;
    logic [1:0] set;
    clr = '0;
    set = '0;
    if (!resetn_i) begin
      trip_q <= '0;
    end else begin
      if (write_i && addr_i == `AIATM_OFF_TRIP_CLR) begin
        clr = wdata_i[1:0];
      end
      set = trip_set | qualified[3:2];
      trip_q <= (trip_q & ~clr) | set;
    end
  end

  // Registered event outputs
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      alarm_low_o  <= 1'b0;
      alarm_high_o <= 1'b0;
      trip_low_o   <= 1'b0;
      trip_high_o  <= 1'b0;
    end else begin
      alarm_low_o  <= qualified[0];
      alarm_high_o <= qualified[1];
      trip_low_o   <= trip_q[0];
      trip_high_o  <= trip_q[1];
    end
  end
endmodule

`default_nettype wire

// ---- hdl/aiatm_pkg.sv ----
/*
  Types shared by the analog input alarm and trip monitor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package aiatm_pkg;
  typedef logic [14:0] aiatm_level_t;    // Scaled value or threshold
  typedef logic [9:0]  aiatm_seconds_t;  // Delay or grace in seconds
  typedef enum logic [1:0] {
    AIATM_ALARM_LO,
    AIATM_ALARM_HI,
    AIATM_TRIP_LO,
    AIATM_TRIP_HI
  } aiatm_elem_e;
endpackage

`default_nettype wire

// ---- hdl/aiatm_qual_timer.sv ----
/*
  Qualifying delay timer for one threshold element.
  Assumes a one-cycle tick once per second from the parent.
*/
`default_nettype none

module aiatm_qual_timer #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // Timebase and condition
  input  wire logic         tick_i,
  input  wire logic         enable_i,
  input  wire logic         cond_i,
  input  wire logic [W-1:0] delay_i,
  // Result
  output logic              qualified_o
);
  logic [W-1:0] count_q;
  logic         active;

  // Condition counts only while enabled and delay not off
  assign active = enable_i && cond_i && (delay_i != '0);

  // Seconds spent continuously in the condition, restart on a break
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else if (!active) begin
      count_q <= '0;
    end else if (tick_i && count_q < delay_i) begin
      count_q <= count_q + W'(1);
    end
  end

  assign qualified_o = active && (count_q >= delay_i);
endmodule

`default_nettype wire

// ---- testbench/aiatm_loop_model.sv ----
/*
  Transducer loop model: drives the digitised loop code toward a target.
  Assumes the bench changes target and slew mode after rising edges.
*/
`default_nettype none

module aiatm_loop_model (
  // Clock and control
  input wire logic        clock_i,
  input wire logic [12:0] target_i,
  input wire logic        slow_i,
  // Loop code to the monitor
  output logic     [12:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Settle at once, or ramp 256 codes a cycle like a lagging sensor
  always_ff @(posedge clock_i) begin
    if (!slow_i || (code_o > target_i ? code_o - target_i
        : target_i - code_o) < 13'h0100) code_o <= target_i;
    else if (code_o < target_i) code_o <= code_o + 13'h0100;
    else code_o <= code_o - 13'h0100;
  end
endmodule

`default_nettype wire

// ---- testbench/aiatm_monitor_properties.sv ----
/*
  Port checker of the analog input alarm and trip monitor.
  Assumes it is bound to aiatm_monitor and sees only its ports.
*/
`default_nettype none

module aiatm_monitor_chk (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        resetn_i,
  // Register writes and loop code
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        write_i,
  input wire logic [12:0] loop_code_i,
  // Events
  input wire logic        alarm_low_o,
  input wire logic        alarm_high_o,
  input wire logic        trip_low_o,
  input wire logic        trip_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] lvl_q [4];
  logic [14:0] mn_q;
  logic [14:0] mx_q;
  int          sc;
  logic [3:0]  c;
  logic [1:0]  clr;

  // Shadow of the levels and scale end points
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      lvl_q <= '{default: '0};
      mn_q  <= '0;
      mx_q  <= 15'h03e8;
    end else if (write_i) begin
      // Only the exact level words, as the design decodes them
      if (addr_i < 8'h20 && addr_i[2:0] == 3'h0) begin
        lvl_q[addr_i[4:3]] <= wdata_i[14:0];
      end
      if (addr_i == 8'h28) mn_q <= wdata_i[14:0];
      if (addr_i == 8'h2c) mx_q <= wdata_i[14:0];
    end
  end

  // Scaled value and the four threshold conditions
  always_comb begin
    sc = int'(mn_q);
    if (mx_q > mn_q) sc = sc + ((int'(loop_code_i > 13'h1000 ? 13'h1000
      : loop_code_i) * int'(mx_q - mn_q)) >>> 12);
    c[0] = lvl_q[0] != '0 && sc < int'(lvl_q[0]);
    c[1] = lvl_q[1] != '0 && sc > int'(lvl_q[1]);
    c[2] = lvl_q[2] != '0 && sc < int'(lvl_q[2]);
    c[3] = lvl_q[3] != '0 && sc > int'(lvl_q[3]);
  end
  assign clr = {2{write_i && addr_i == 8'h38}} & wdata_i[1:0];

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_ALO_RISE: assert property ($rose(alarm_low_o) |-> $past(c[0], 3))
    else $error("low alarm without low value");
  AST_AHI_RISE: assert property ($rose(alarm_high_o) |-> $past(c[1], 3))
    else $error("high alarm without high value");
  AST_TLO_RISE: assert property ($rose(trip_low_o) |-> $past(c[2], 3))
    else $error("low trip without low value");
  AST_THI_RISE: assert property ($rose(trip_high_o) |-> $past(c[3], 3))
    else $error("high trip without high value");
  AST_ALO_DROP: assert property ((!c[0]) [*5] |-> !alarm_low_o)
    else $error("low alarm outlives its condition");
  AST_AHI_DROP: assert property ((!c[1]) [*5] |-> !alarm_high_o)
    else $error("high alarm outlives its condition");
  AST_TLO_HOLD: assert property (trip_low_o && !clr[0] && !$past(clr[0])
    |=> trip_low_o)
    else $error("low trip dropped without clear");
  AST_THI_HOLD: assert property (trip_high_o && !clr[1] && !$past(clr[1])
    |=> trip_high_o)
    else $error("high trip dropped without clear");

  // Main scenarios reached
  cover property ($rose(alarm_high_o));
  cover property ($rose(trip_low_o));
  cover property ($fell(trip_high_o));
endmodule

`default_nettype wire

// ---- testbench/test_analog_input_alarm_trip_monitor.sv ----
/*
  Self-checking bench of the analog input alarm and trip monitor.
  Assumes design, package, checker and loop model compiled before it.
*/
`default_nettype none

module test_analog_input_alarm_trip_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 10;
  logic        clock_i, resetn_i, write_i, read_i, start, run, slow;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [12:0] tgt, code;
  logic [3:0]  ev;
  int          mismatches, n_tests, j;
  int unsigned x = 21;

  aiatm_loop_model lm (.clock_i, .target_i(tgt), .slow_i(slow),
    .code_o(code));
  aiatm_monitor #(.TICK_CYCLES(T)) dut (.clock_i, .resetn_i,
    .addr_i(addr), .wdata_i(wdata), .write_i, .read_i, .rdata_o(rdata),
    .loop_code_i(code), .motor_start_i(start), .motor_running_i(run),
    .alarm_low_o(ev[0]), .alarm_high_o(ev[1]), .trip_low_o(ev[2]),
    .trip_high_o(ev[3]));

  // Clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(logic [7:0] a, int d);
    @(posedge clock_i);
    addr <= a;
    wdata <= 32'(d);
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [7:0] a, int e);
    @(posedge clock_i);
    addr <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 chk(nm, rdata, 32'(e));
  endtask
  // Bounded wait for event i to reach v, elapsed cycles within lo..hi
  task automatic wt(int i, logic v, int lo, int hi);
    int k;
    k = 0;
    #1;
    while (ev[i] !== v && k <= hi) begin
      @(posedge clock_i);
      #1 k++;
    end
    chk($sformatf("event %0d time", i), 32'(k >= lo && k <= hi), 1);
    if (k > hi) complete_run();
  endtask
  function automatic int xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return int'(x % 4097);
  endfunction
  // Trip threshold j with start grace g; for g > 0 first healthy in time, then not
  task automatic gr(int j, int g, int lo, int hi);
    int ok, uh;
    ok = j == 2 ? 3277 : 819;
    uh = j == 2 ? 819 : 3277;
    wr(j == 2 ? 8'h20 : 8'h24, g);
    wr(8'(8 * j), 500);
    wr(8'(8 * j + 4), 50);
    tgt <= 13'(uh);
    cyc(6);
    if (g > 0) begin
      start <= 1'b1;
      run <= 1'b1;
      slow <= 1'b1;
      @(posedge clock_i);
      start <= 1'b0;
      tgt <= 13'(ok);
      cyc(4 * T);
      #1 chk("healthy in grace", ev[j], 0);
      slow <= 1'b0;
      run <= 1'b0;
      tgt <= 13'(uh);
      cyc(6);
    end
    start <= 1'b1;
    run <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    wt(j, 1, lo, hi);
    tgt <= 13'(ok);
    run <= 1'b0;
    wr(8'h38, 1 << (j - 2));
    wt(j, 0, 0, 6);
    wr(8'(8 * j), 0);
    $display("test grace %0d on %0d done", g, j);
  endtask

  // Main sequence
  initial begin
    int d, ok, uh;
    {resetn_i, write_i, read_i, start, run, slow} = '0;
    {addr, wdata, tgt} = '0;
    mismatches = 0;
    n_tests = 0;
    cyc(4);
    resetn_i <= 1'b1;
    rchk("delay", 8'h04, 5);
    rchk("grace", 8'h20, 5);
    rchk("max", 8'h2c, 1000);
    rchk("level", 8'h18, 0);
    rchk("unmapped", 8'h3c, 0);
    wr(8'h28, 100);
    wr(8'h2c, 2000);
    for (j = 0; j < 10; j++) begin
      d = j == 0 ? 0 : j == 1 ? 4096 : j == 2 ? 8191 : xs();
      tgt <= 13'(d);
      if (d > 4096) d = 4096; // Codes above full scale read as full scale
      cyc(3);
      rchk("scaled", 8'h34, 100 + d * 1900 / 4096);
    end
    wr(8'h28, 0);
    wr(8'h2c, 1000);
    $display("test scale done");
    for (j = 0; j < 4; j++) begin
      ok = j % 2 ? 819 : 3277;
      uh = j % 2 ? 3277 : 819;
      tgt <= 13'(ok);
      if (j > 1) wr(j == 2 ? 8'h20 : 8'h24, 1023);
      wr(8'(8 * j), 500);
      wr(8'(8 * j + 4), 2);
      tgt <= 13'(uh);
      cyc(8);
      tgt <= 13'(ok);
      cyc(4);
      tgt <= 13'(uh);
      wt(j, 1, T, 2 * T + 8);
      rchk("status", 8'h30, 1 << j);
      tgt <= 13'(ok);
      if (j < 2) wt(j, 0, 0, 8);
      else begin
        cyc(5);
        #1 chk("latched", ev[j], 1);
        wr(8'h38, 1 << (j - 2));
        wt(j, 0, 0, 6);
      end
      wr(8'(8 * j), 0);
      tgt <= 13'(uh);
      cyc(3 * T);
      #1 chk("off", ev[j], 0);
      // Delay zero also keeps the element inactive
      wr(8'(8 * j + 4), 0);
      wr(8'(8 * j), 500);
      cyc(3 * T);
      #1 chk("delay off", ev[j], 0);
      wr(8'(8 * j), 0);
      tgt <= 13'(ok);
      $display("test element %0d done", j);
    end
    gr(2, 0, 0, 5);
    gr(3, 0, 0, 5);
    gr(2, 2, T, 2 * T + 8);
    gr(3, 2, T, 2 * T + 8);
    complete_run();
  end
endmodule

bind aiatm_monitor aiatm_monitor_chk chk (.clock_i, .resetn_i, .addr_i,
  .wdata_i, .write_i, .loop_code_i, .alarm_low_o, .alarm_high_o,
  .trip_low_o, .trip_high_o);

`default_nettype wire
